// >>> hw/uesi_defines.svh
// Offsets, field positions, reset values and timing counts of the endpoint pipe block.
`ifndef UESI_DEFINES_SVH
`define UESI_DEFINES_SVH
`define UESI_OFF_EP_BASE      8'h00
`define UESI_OFF_STATUS       8'h06
`define UESI_OFF_IRQ_EN       8'h07
`define UESI_OFF_PIPE_CTRL    8'h08
`define UESI_OFF_ACC_FLAGS    8'h09
`define UESI_OFF_CLK_CTRL     8'h0A
`define UESI_BIT_SUSPEND      0
`define UESI_BIT_RESUME       1
`define UESI_BIT_BUS_RESET    2
`define UESI_BIT_REMOTE_WAKE  3
`define UESI_BIT_PLL_PD       4
`define UESI_BIT_PHY_PD       7
`define UESI_BIT_USB_CLK_EN   0
`define UESI_RST_IRQ_EN       6'h00
`define UESI_RST_PIPE_EN      5'h00
`define UESI_RST_CLK_CTRL     1'b1
`define UESI_CLK_MHZ          200
`define UESI_SUSPEND_IDLE_US  3000
`define UESI_SUSPEND_IDLE_CYCLES (`UESI_SUSPEND_IDLE_US * `UESI_CLK_MHZ)
`define UESI_INT_PULSE_CYCLES 8
`define UESI_DEPTH_SMALL      8
`define UESI_DEPTH_LARGE      64
`endif

// >>> hw/uesi_pkg.sv
// Types and the helper function shared by the endpoint pipe block.
`include "uesi_defines.svh"
package uesi_pkg;
    typedef logic [7:0] uesi_byte_t;
    typedef enum logic [2:0] {
        LINK_ACTIVE  = 3'b001,
        LINK_SUSPEND = 3'b010,
        LINK_RESUME  = 3'b100
    } uesi_link_state_t;
    // Endpoints 3 and 5 carry bulk traffic and get the deep pipes.
    function automatic int uesi_ep_depth(input int ep);
        return (ep == 3 || ep == 5) ? `UESI_DEPTH_LARGE : `UESI_DEPTH_SMALL;
    endfunction
endpackage

// >>> hw/uesi_pipe_if.sv
// Carrier between the top module and one endpoint pipe.
`timescale 1ns/10ps
interface uesi_pipe_if #(parameter int W = 8);
    logic         push;
    logic         pop;
    logic [W-1:0] wdata;
    logic [W-1:0] rdata;
    logic         full;
    logic         empty;
    modport pipe (input push, input pop, input wdata, output rdata, output full, output empty);
    modport user (output push, output pop, output wdata, input rdata, input full, input empty);
endinterface

// >>> hw/uesi_pipe.sv
// One endpoint data pipe: a first-in first-out byte store.
`timescale 1ns/10ps
module uesi_pipe
    import uesi_pkg::*;
#(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic    core_clk,
    input  wire logic    rst_b,
    uesi_pipe_if.pipe    p
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0]   count_reg;
    logic          do_push;
    logic          do_pop;

    // Refused accesses leave contents and pointers untouched.
    assign do_push = p.push && (count_reg != (AW+1)'(DEPTH));
    assign do_pop  = p.pop && (count_reg != '0);
    assign p.full  = (count_reg == (AW+1)'(DEPTH));
    assign p.empty = (count_reg == '0);
    assign p.rdata = mem[rd_ptr_reg];

    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= p.wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule // uesi_pipe

// >>> hw/uesi_top.sv
// Endpoint pipes, suspend and wake-up tracking and the interrupt pulse of the USB companion.
`timescale 1ns/10ps
`include "uesi_defines.svh"
module uesi_top
    import uesi_pkg::*;
#(
    parameter int unsigned IDLE_CYCLES  = `UESI_SUSPEND_IDLE_CYCLES,
    parameter int unsigned PULSE_CYCLES = `UESI_INT_PULSE_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       usb_activity,
    input  wire logic       usb_resume,
    input  wire logic       usb_reset,
    input  wire logic       host_wr,
    input  wire logic       host_rd,
    input  wire logic [2:0] host_ep,
    input  wire logic [7:0] host_wdata,
    output logic      [7:0] host_rdata,
    output logic            host_done,
    output logic            int_b,
    output logic            usb_wake,
    output logic            phy_powerdown,
    output logic            pll_powerdown,
    output logic            usb_clock_enable
);
    localparam int NEP = 6;
    localparam int IW  = $clog2(IDLE_CYCLES + 1);
    localparam int PW  = $clog2(PULSE_CYCLES + 1);

    logic [1:0] rst_sync_reg;
    logic       rst_sync_b;
    logic [2:0] pin_s1_reg;
    logic [2:0] pin_s2_reg;
    logic [2:0] pin_d_reg;
    logic       act_s;
    logic       res_s;
    logic       bus_reset_flag_s;

    uesi_link_state_t state_reg;
    logic [IW-1:0]    idle_cnt_reg;
    logic             bus_idle_flag_flag_reg;
    logic             resume_flag_reg;
    logic             bus_reset_flag_reg;
    logic             remote_wake_reg;
    logic             pll_pd_reg;
    logic             phy_pd_reg;
    logic [5:1]       pipe_en_reg;
    logic [NEP-1:0]   irq_en_reg;
    logic [NEP-1:0]   acc_flag_reg;
    logic             clk_en_reg;
    logic [PW-1:0]    int_cnt_reg;
    logic             int_b_reg;
    logic             wake_reg;
    uesi_byte_t       reg_rdata_reg;
    uesi_byte_t       host_rdata_reg;
    logic             host_done_reg;

    logic [NEP-1:0]   pipe_on;
    logic [NEP-1:0]   mcu_wr_hit;
    logic [NEP-1:0]   mcu_rd_hit;
    logic [NEP-1:0]   host_wr_hit;
    logic [NEP-1:0]   host_rd_hit;
    logic [NEP-1:0]   host_acc;
    logic [NEP-1:0]   ep_full;
    logic [NEP-1:0]   ep_empty;
    uesi_byte_t       ep_rdata [NEP];
    logic [NEP-1:0]   acc_clr;
    logic [NEP-1:0]   set_clr_both;
    logic [NEP-1:0]   ep_event;
    logic             bus_idle_flag_set;
    logic             resume_set;
    logic             leave_bus_idle_flag;
    logic             reset_set;
    logic             any_event;
    uesi_byte_t       rd_mux;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_sync_b = rst_sync_reg[1];

    // Bus pins are asynchronous; edges are taken from the second stage only.
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pin_s1_reg <= 3'h0;
            pin_s2_reg <= 3'h0;
            pin_d_reg  <= 3'h0;
        end else begin
            pin_s1_reg <= {usb_reset, usb_resume, usb_activity};
            pin_s2_reg <= pin_s1_reg;
            pin_d_reg  <= pin_s2_reg;
        end
    end
    assign act_s  = pin_s2_reg[0];
    assign res_s  = pin_s2_reg[1];
    assign bus_reset_flag_s = pin_s2_reg[2];

    assign pipe_on = {pipe_en_reg, 1'b1};

    // Endpoint pipes; a host write beats a software write or pop of one pipe in a cycle, but a host read and a software write both go ahead.
    for (genvar i = 0; i < NEP; i++) begin : gen_ep
        uesi_pipe_if #(.W(8)) pif ();
        uesi_pipe #(.W(8), .DEPTH(uesi_ep_depth(i))) u_pipe (
            .core_clk (core_clk),
            .rst_b    (rst_sync_b),
            .p        (pif.pipe)
        );
        assign mcu_wr_hit[i]  = reg_wr && (reg_addr == `UESI_OFF_EP_BASE + 8'(i)) && pipe_on[i];
        assign mcu_rd_hit[i]  = reg_rd && (reg_addr == `UESI_OFF_EP_BASE + 8'(i)) && pipe_on[i];
        assign host_wr_hit[i] = host_wr && (host_ep == 3'(i)) && pipe_on[i];
        assign host_rd_hit[i] = host_rd && (host_ep == 3'(i)) && pipe_on[i];
        assign pif.push  = host_wr_hit[i] || mcu_wr_hit[i];
        assign pif.pop   = host_rd_hit[i] || (mcu_rd_hit[i] && !host_wr_hit[i]);
        assign pif.wdata = host_wr_hit[i] ? host_wdata : reg_wdata;
        assign ep_full[i]  = pif.full;
        assign ep_empty[i] = pif.empty;
        assign ep_rdata[i] = pif.rdata;
        assign host_acc[i] = (host_wr_hit[i] && !pif.full) || (host_rd_hit[i] && !pif.empty);
    end

    // Link state: idle count, host resume, and leaving only at the end of resume.
    assign bus_idle_flag_set   = (state_reg == LINK_ACTIVE) && !act_s
                        && (idle_cnt_reg == IW'(IDLE_CYCLES - 1));
    assign resume_set = (state_reg == LINK_SUSPEND) && res_s && !pin_d_reg[1];
    assign leave_bus_idle_flag = (state_reg == LINK_RESUME) && !res_s;
    assign reset_set  = bus_reset_flag_s && !pin_d_reg[2];

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state_reg    <= LINK_ACTIVE;
            idle_cnt_reg <= '0;
        end else begin
            case (state_reg)
                LINK_ACTIVE: begin
                    idle_cnt_reg <= act_s ? '0 : idle_cnt_reg + 1'b1;
                    if (bus_idle_flag_set) begin
                        state_reg <= LINK_SUSPEND;
                    end
                end
                LINK_SUSPEND: begin
                    idle_cnt_reg <= '0;
                    if (resume_set) begin
                        state_reg <= LINK_RESUME;
                    end
                end
                LINK_RESUME: begin
                    if (leave_bus_idle_flag) begin
                        state_reg <= LINK_ACTIVE;
                    end
                end
                default: begin
                    state_reg <= LINK_ACTIVE;
                end
            endcase
        end
    end

    // Link flags follow the link alone; software writes cannot reach them.
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            bus_idle_flag_flag_reg      <= 1'b0;
            resume_flag_reg    <= 1'b0;
            bus_reset_flag_reg <= 1'b0;
        end else begin
            if (bus_idle_flag_set) begin
                bus_idle_flag_flag_reg <= 1'b1;
            end else if (leave_bus_idle_flag) begin
                bus_idle_flag_flag_reg <= 1'b0;
            end
            if (resume_set) begin
                resume_flag_reg <= 1'b1;
            end else if (leave_bus_idle_flag) begin
                resume_flag_reg <= 1'b0;
            end
            if (reset_set) begin
                bus_reset_flag_reg <= 1'b1;
            end else if (!bus_reset_flag_s && act_s) begin
                bus_reset_flag_reg <= 1'b0;
            end
        end
    end

    // Access flags: hardware set beats a software clear in the same cycle.
    assign acc_clr      = (reg_wr && reg_addr == `UESI_OFF_ACC_FLAGS) ? reg_wdata[5:0] : '0;
    assign set_clr_both = host_acc & acc_clr;
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            acc_flag_reg <= '0;
        end else begin
            acc_flag_reg <= (acc_flag_reg & ~acc_clr) | host_acc;
        end
    end

    // Software-written control registers.
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            remote_wake_reg <= 1'b0;
            pll_pd_reg      <= 1'b0;
            phy_pd_reg      <= 1'b0;
            pipe_en_reg     <= `UESI_RST_PIPE_EN;
            irq_en_reg      <= `UESI_RST_IRQ_EN;
            clk_en_reg      <= `UESI_RST_CLK_CTRL;
        end else if (reg_wr) begin
            case (reg_addr)
                `UESI_OFF_STATUS: begin
                    remote_wake_reg <= reg_wdata[`UESI_BIT_REMOTE_WAKE];
                    pll_pd_reg      <= reg_wdata[`UESI_BIT_PLL_PD];
                end
                `UESI_OFF_PIPE_CTRL: begin
                    phy_pd_reg  <= reg_wdata[`UESI_BIT_PHY_PD];
                    pipe_en_reg <= reg_wdata[5:1];
                end
                `UESI_OFF_IRQ_EN: begin
                    irq_en_reg <= reg_wdata[5:0];
                end
                `UESI_OFF_CLK_CTRL: begin
                    clk_en_reg <= reg_wdata[`UESI_BIT_USB_CLK_EN];
                end
                default: begin
                end
            endcase
        end
    end

    // Interrupt sources; a new event during a pulse restarts it, so bursts merge.
    assign ep_event  = host_acc & pipe_on & irq_en_reg;
    assign any_event = bus_idle_flag_set || resume_set || reset_set || (ep_event != '0);
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            int_cnt_reg <= '0;
            int_b_reg   <= 1'b1;
        end else if (any_event) begin
            int_cnt_reg <= PW'(PULSE_CYCLES - 1);
            int_b_reg   <= 1'b0;
        end else if (int_cnt_reg != '0) begin
            int_cnt_reg <= int_cnt_reg - 1'b1;
        end else begin
            int_b_reg <= 1'b1;
        end
    end

    // The wake pulse follows the software bit, and only while the link sleeps.
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= remote_wake_reg && (state_reg == LINK_SUSPEND);
        end
    end

    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr)
            `UESI_OFF_STATUS:    rd_mux = {3'h0, pll_pd_reg, remote_wake_reg,
                                           bus_reset_flag_reg, resume_flag_reg, bus_idle_flag_flag_reg};
            `UESI_OFF_IRQ_EN:    rd_mux = {2'h0, irq_en_reg};
            `UESI_OFF_PIPE_CTRL: rd_mux = {phy_pd_reg, 1'b0, pipe_en_reg, 1'b0};
            `UESI_OFF_ACC_FLAGS: rd_mux = {2'h0, acc_flag_reg};
            `UESI_OFF_CLK_CTRL:  rd_mux = {7'h00, clk_en_reg};
            default: begin
                for (int k = 0; k < NEP; k++) begin
                    if (mcu_rd_hit[k] && !ep_empty[k]) begin
                        rd_mux = ep_rdata[k];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            reg_rdata_reg  <= 8'h00;
            host_rdata_reg <= 8'h00;
            host_done_reg  <= 1'b0;
        end else begin
            if (reg_rd) begin
                reg_rdata_reg <= rd_mux;
            end
            host_done_reg <= host_acc != '0;
            if (host_rd && (host_rd_hit != '0) && !ep_empty[host_ep]) begin
                host_rdata_reg <= ep_rdata[host_ep];
            end
        end
    end

    assign reg_rdata        = reg_rdata_reg;
    assign host_rdata       = host_rdata_reg;
    assign host_done        = host_done_reg;
    assign int_b            = int_b_reg;
    assign usb_wake         = wake_reg;
    assign phy_powerdown    = phy_pd_reg;
    assign pll_powerdown    = pll_pd_reg;
    assign usb_clock_enable = clk_en_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_b);

    a_idle_suspend: assert property (bus_idle_flag_set |=> bus_idle_flag_flag_reg && state_reg == LINK_SUSPEND)
        else $error("idle bus did not enter suspend");
    a_suspend_int: assert property ($rose(bus_idle_flag_flag_reg) |-> !int_b_reg)
        else $error("suspend gave no interrupt pulse");
    a_resume_flag: assert property (resume_set |=> resume_flag_reg && !int_b_reg)
        else $error("resume not flagged");
    a_stay_resume: assert property (state_reg == LINK_RESUME && res_s |=> bus_idle_flag_flag_reg)
        else $error("suspend left during resume");
    a_leave_clear: assert property (leave_bus_idle_flag |=> !bus_idle_flag_flag_reg && !resume_flag_reg)
        else $error("flags not cleared on leaving");
    a_ep_int: assert property ((ep_event != '0) |=> !int_b_reg ##1 !int_b_reg)
        else $error("enabled access gave no pulse");
    a_set_wins: assert property ((set_clr_both != '0) |=>
                                 ((acc_flag_reg & $past(set_clr_both)) == $past(set_clr_both)))
        else $error("access flag lost to clear");
    a_int_pulse: assert property ($fell(int_b_reg) |-> (!int_b_reg)[*4])
        else $error("interrupt pulse too short");
    a_wake_out: assert property (remote_wake_reg && state_reg == LINK_SUSPEND |=> usb_wake)
        else $error("no wake pulse");
    a_ro_flags: assert property (!bus_idle_flag_set && !leave_bus_idle_flag |=> $stable(bus_idle_flag_flag_reg))
        else $error("suspend flag moved without link cause");

    c_suspend: cover property (bus_idle_flag_set);
    c_leave: cover property (leave_bus_idle_flag);
    c_ep_irq: cover property (ep_event != '0);
    c_full: cover property (ep_full[3]);
endmodule // uesi_top

// >>> sim/uesi_host_model.sv
// Far-side model: SIE pipe accesses and the host answer to remote wake.
`timescale 1ns/10ps
module uesi_host_model (
    input  wire logic       core_clk,
    input  wire logic       usb_wake,
    input  wire logic       host_done,
    input  wire logic [7:0] host_rdata,
    output logic            usb_resume,
    output logic            host_wr,
    output logic            host_rd,
    output logic      [2:0] host_ep,
    output logic      [7:0] host_wdata
);
    initial begin
        usb_resume = 1'b0;
        host_wr    = 1'b0;
        host_rd    = 1'b0;
        host_ep    = 3'h0;
        host_wdata = 8'h00;
    end
    // Data is inverted after use so a stale byte never passes for a fresh one.
    task automatic xfer(input logic wr, input logic [2:0] ep, input logic [7:0] d,
                        output logic done, output logic [7:0] q);
        @(negedge core_clk);
        host_wr = wr;
        host_rd = ~wr;
        host_ep = ep;
        host_wdata = d;
        @(negedge core_clk);
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = ~d;
        done = host_done;
        q = host_rdata;
    endtask
    // The host answers the end of the wake pulse with resume a little later.
    always @(posedge usb_wake) begin
        @(negedge usb_wake);
        repeat (10) @(negedge core_clk);
        usb_resume = 1'b1;
        repeat (40) @(negedge core_clk);
        usb_resume = 1'b0;
    end
endmodule // uesi_host_model

// >>> sim/tb_uesi_top.sv
// Self-checking bench for the endpoint pipe and suspend block.
`timescale 1ns/10ps
module tb_uesi_top;
    logic        core_clk = 1'b0;
    logic        rst_b, reg_wr, reg_rd, usb_activity, usb_reset, saw_low;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, host_rdata, host_wdata, q;
    logic        host_done, int_b, usb_wake, phy_pd, pll_pd, clk_en;
    logic        usb_resume, host_wr, host_rd, done;
    logic [2:0]  host_ep;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          i, ep, dep, n, w;
    logic [23:0] rows [0:8] = '{24'h07FF3F, 24'h070000, 24'h08FFBE, 24'h080000,
        24'h06FF18, 24'h060000, 24'h0A0000, 24'h0AFF01, 24'h20FF00};
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (int_b === 1'b0) saw_low <= 1'b1;
    uesi_top #(.IDLE_CYCLES(50), .PULSE_CYCLES(8)) i_uesi_top (
        .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .usb_activity(usb_activity), .usb_resume(usb_resume), .usb_reset(usb_reset),
        .host_wr(host_wr), .host_rd(host_rd), .host_ep(host_ep),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .host_done(host_done),
        .int_b(int_b), .usb_wake(usb_wake), .phy_powerdown(phy_pd),
        .pll_powerdown(pll_pd), .usb_clock_enable(clk_en));
    uesi_host_model i_uesi_host_model (
        .core_clk(core_clk), .usb_wake(usb_wake), .host_done(host_done),
        .host_rdata(host_rdata), .usb_resume(usb_resume), .host_wr(host_wr),
        .host_rd(host_rd), .host_ep(host_ep), .host_wdata(host_wdata));
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        r = reg_rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [7:0] r;
        rd(a, r);
        chk(nm, r, e);
    endtask
    // Waits for the low pulse, then counts its length in cycles.
    task automatic pulse(output int wt, output int len);
        wt = 0;
        len = 0;
        while (int_b !== 1'b0 && wt < 120) begin
            @(negedge core_clk);
            wt++;
        end
        while (int_b === 1'b0 && len < 40) begin
            @(negedge core_clk);
            len++;
        end
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        test_done;
    end
    initial begin
        {rst_b, reg_wr, reg_rd, usb_reset, saw_low} = 5'h00;
        {reg_addr, reg_wdata} = 16'h0000;
        usb_activity = 1'b1;
        repeat (8) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (3) @(negedge core_clk);
        chk("idle_pins", {int_b, usb_wake, clk_en, pll_pd, phy_pd}, 8'h14);
        rdc(8'h07, 8'h00, "irq_en_rst");
        rdc(8'h08, 8'h00, "pipe_rst");
        for (i = 0; i < 9; i++) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rdc(rows[i][23:16], rows[i][7:0], "row");
        end
        // Every pipe is filled one past its depth, then drained one past empty.
        wr(8'h08, 8'h3E);
        saw_low = 1'b0;
        for (ep = 0; ep < 6; ep++) begin
            dep = (ep == 3 || ep == 5) ? 64 : 8;
            n = 0;
            for (i = 0; i <= dep; i++) begin
                i_uesi_host_model.xfer(1'b1, ep[2:0], 8'(ep * 16 + i), done, q);
                if (done === 1'b1) n++;
            end
            chk("fill", 8'(n), 8'(dep));
            for (i = 0; i <= dep; i++) begin
                rd(8'(ep), q);
                chk("drain", q, (i < dep) ? 8'(ep * 16 + i) : 8'h00);
            end
        end
        chk("no_irq", {7'h00, saw_low}, 8'h00);
        rdc(8'h09, 8'h3F, "acc_flags");
        wr(8'h09, 8'h3F);
        rdc(8'h09, 8'h00, "acc_clear");
        wr(8'h07, 8'h12);
        wr(8'h04, 8'hA5);
        i_uesi_host_model.xfer(1'b0, 3'h4, 8'h00, done, q);
        chk("host_rd", q, 8'hA5);
        pulse(w, n);
        chk("ep_pulse", 8'(n), 8'h08);
        i_uesi_host_model.xfer(1'b1, 3'h1, 8'h11, done, q);
        i_uesi_host_model.xfer(1'b1, 3'h1, 8'h22, done, q);
        pulse(w, n);
        chk("merged", 8'(n), 8'h08);
        // A software clear that meets a fresh host access in one cycle must lose.
        fork
            wr(8'h09, 8'h12);
            i_uesi_host_model.xfer(1'b1, 3'h1, 8'h44, done, q);
        join
        pulse(w, n);
        chk("set_pulse", 8'(n), 8'h08);
        rdc(8'h09, 8'h02, "set_wins");
        wr(8'h08, 8'h3C);
        saw_low = 1'b0;
        i_uesi_host_model.xfer(1'b1, 3'h1, 8'h33, done, q);
        rdc(8'h01, 8'h00, "off_pipe");
        chk("off_acc", {6'h00, done, saw_low}, 8'h00);
        wr(8'h08, 8'h3E);
        usb_activity = 1'b0;
        pulse(w, n);
        chk("idle_wait", 8'(w >= 50 && w <= 60), 8'h01);
        chk("bus_idle_flag_pulse", 8'(n), 8'h08);
        rdc(8'h06, 8'h01, "suspended");
        wr(8'h0A, 8'h00);
        wr(8'h06, 8'h10);
        wr(8'h08, 8'hBE);
        wr(8'h06, 8'h18);
        @(negedge core_clk);
        chk("low_power", {usb_wake, clk_en, pll_pd, phy_pd}, 8'h0B);
        // Software holds the wake bit for 2 us at 200 MHz before dropping it.
        repeat (400) @(negedge core_clk);
        chk("wake_held", {7'h00, usb_wake}, 8'h01);
        wr(8'h06, 8'h10);
        pulse(w, n);
        chk("res_pulse", 8'(n), 8'h08);
        rdc(8'h06, 8'h13, "resuming");
        wr(8'h0A, 8'h01);
        wr(8'h06, 8'h00);
        wr(8'h08, 8'h3E);
        w = 0;
        while (usb_resume === 1'b1 && w < 100) begin
            @(negedge core_clk);
            w++;
        end
        usb_activity = 1'b1;
        repeat (4) @(negedge core_clk);
        rdc(8'h06, 8'h00, "awake");
        chk("powered", {usb_wake, clk_en, pll_pd, phy_pd}, 8'h04);
        usb_reset = 1'b1;
        pulse(w, n);
        chk("rst_pulse", 8'(n), 8'h08);
        wr(8'h06, 8'h00);
        rdc(8'h06, 8'h04, "bus_rst");
        usb_reset = 1'b0;
        repeat (4) @(negedge core_clk);
        rdc(8'h06, 8'h00, "rst_gone");
        // A reset in mid-run must flush pipe 0 and restore the clock, power-down and pipe-enable bits.
        wr(8'h00, 8'h5A);
        wr(8'h0A, 8'h00);
        rst_b = 1'b0;
        repeat (2) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (3) @(negedge core_clk);
        chk("rst_pins", {int_b, usb_wake, clk_en, pll_pd, phy_pd}, 8'h14);
        rdc(8'h08, 8'h00, "pipe_rst2");
        rdc(8'h09, 8'h00, "acc_rst");
        rdc(8'h00, 8'h00, "ep_flush");
        test_done;
    end
endmodule // tb_uesi_top
